/* File: logic/ctc_defines.svh */
// constants for the channel trap control block
// assumes 36-bit words, bit 0 = sign (S), bit 35 = low end, 15-bit addresses
`ifndef CTC_DEFINES_SVH
`define CTC_DEFINES_SVH
`define CTC_NUM_CH        5
`define CTC_ADDR_W        15
`define CTC_WORD_W        36
`define CTC_MASK_RESET    4'h0
// trap record words, octal 12/14/16/20/22
`define CTC_REC_A         15'h000a
`define CTC_REC_B         15'h000c
`define CTC_REC_C         15'h000e
`define CTC_REC_D         15'h0010
`define CTC_REC_E         15'h0012
// record bit positions, word numbering 0..35 from the sign end
`define CTC_BIT_UREC      8
`define CTC_BIT_TELE      9
`define CTC_BIT_HOST      10
`define CTC_BIT_XATT      11
`define CTC_BIT_PAR       16
`define CTC_BIT_OPC       17
// enable-traps source word positions
`define CTC_SRC_ATT       7
`define CTC_SRC_PAR       16
`define CTC_SRC_DD        25
`define CTC_SRC_OPC       34
// mask field positions
`define CTC_MSK_ATT       3
`define CTC_MSK_PAR       2
`define CTC_MSK_DD        1
`define CTC_MSK_OPC       0
`endif

/* File: logic/ctc_pkg.sv */
// types of the channel trap control block
// assumes ctc_defines.svh is on the include path
`include "ctc_defines.svh"
package ctc_pkg;
    typedef logic [`CTC_WORD_W-1:0] ctc_word_t;
    typedef logic [`CTC_ADDR_W-1:0] ctc_addr_t;
    typedef enum logic [0:0] {
        CTC_IDLE,
        CTC_STORE
    } ctc_state_e;
    // condition inputs, one bit per channel, plus single unit record, teleprocessing and host attention bits for channel A
    typedef struct packed {
        logic [`CTC_NUM_CH-1:0] in_use;
        logic [`CTC_NUM_CH-1:0] parity_err;
        logic [`CTC_NUM_CH-1:0] ext_attn;
        logic                   unit_rec;
        logic                   tele;
        logic                   host_attn;
    } ctc_chan_s;
    // processor sequencing inputs
    typedef struct packed {
        logic      end_op;
        logic      priv_instr;
        logic      trap_ctl;
        logic      higher_trap;
        logic      enable_traps_instruction;
        logic      restore_channel_trap_instruction;
        logic      reset_data_channel_instruction;
        logic      branch_on_channel_check_instruction;
        logic [2:0] ch_sel;
        logic      console_clr;
        ctc_word_t enb_word;
        ctc_addr_t instr_ctr;
    } ctc_cpu_s;
    // trap store request towards memory
    typedef struct packed {
        logic      store;
        ctc_addr_t store_addr;
        ctc_word_t store_data;
        logic      vector;
        ctc_addr_t vector_addr;
    } ctc_trap_s;
    typedef struct packed {
        ctc_state_e             state;
        logic                   ch_trap_ctl;
        logic                   priv_hold;
        logic [`CTC_NUM_CH*4-1:0] mask;
        logic [`CTC_NUM_CH-1:0] lat_opc;
        logic [`CTC_NUM_CH-1:0] lat_par;
        logic [`CTC_NUM_CH-1:0] lat_xatt;
        logic                   lat_urec;
        logic                   lat_tele;
        logic                   lat_host;
        logic [`CTC_NUM_CH-1:0] busy_q;
        ctc_trap_s              trap;
        logic                   trc_branch;
    } ctc_state_s;
endpackage

/* File: logic/ctc_trap_ctrl.sv */
// channel trap control: condition latches, masks, priority and record store
// assumes cpu inputs are on ref_clk; channel and console inputs are asynchronous
`timescale 1ns/10ps
module ctc_trap_ctrl
    import ctc_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    input  wire ctc_chan_s               chan,
    input  wire ctc_cpu_s                cpu,
    output ctc_trap_s                    trap,
    output logic [`CTC_NUM_CH-1:0]       xfer_stop,
    output logic [`CTC_NUM_CH-1:0]       addr_hold,
    output logic                         trc_branch,
    output logic                         ch_trap_ctl
);

    // ==========================================================
    // helpers
    function automatic ctc_addr_t rec_addr(input logic [2:0] ch);
        case (ch)
            3'h0:    rec_addr = `CTC_REC_A;
            3'h1:    rec_addr = `CTC_REC_B;
            3'h2:    rec_addr = `CTC_REC_C;
            3'h3:    rec_addr = `CTC_REC_D;
            default: rec_addr = `CTC_REC_E;
        endcase
    endfunction

    // word bit n counted from the sign end
    function automatic int wb(input int n);
        wb = `CTC_WORD_W - 1 - n;
    endfunction

    // ==========================================================
    // input synchronisers
    ctc_chan_s sync1;
    ctc_chan_s sync2;
    logic      clr1;
    logic      clr2;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync1 <= '0;
            sync2 <= '0;
            clr1  <= 1'b0;
            clr2  <= 1'b0;
        end else begin
            sync1 <= chan;
            sync2 <= sync1;
            clr1  <= cpu.console_clr;
            clr2  <= clr1;
        end
    end

    // ==========================================================
    // next state
    ctc_state_s r;
    ctc_state_s next_r;
    logic [`CTC_NUM_CH-1:0] req;
    logic [`CTC_NUM_CH-1:0] ch_sel_dec;
    logic [3:0]             msk [`CTC_NUM_CH];
    logic [3:0]             enb_mask;
    logic [2:0]             win;
    logic                   any;
    ctc_word_t              rec;

    always_comb begin
        next_r = r;
        next_r.trap.store  = 1'b0;
        next_r.trap.vector = 1'b0;
        next_r.trc_branch  = 1'b0;
        next_r.busy_q      = sync2.in_use;
        ch_sel_dec = '0;
        ch_sel_dec[cpu.ch_sel] = 1'b1;
        enb_mask = {cpu.enb_word[wb(`CTC_SRC_ATT)],
                    cpu.enb_word[wb(`CTC_SRC_PAR)],
                    cpu.enb_word[wb(`CTC_SRC_DD)],
                    cpu.enb_word[wb(`CTC_SRC_OPC)]};
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            msk[c] = r.mask[c*4 +: 4];
        end

        // latch clearing by command; the sets come last, further down
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            if (cpu.reset_data_channel_instruction && ch_sel_dec[c]) begin
                next_r.lat_opc[c]  = 1'b0;
                next_r.lat_par[c]  = 1'b0;
                next_r.lat_xatt[c] = 1'b0;
                next_r.mask[c*4 +: 4] = `CTC_MASK_RESET;
            end
            // parity test only works with mask bit zero
            if (cpu.branch_on_channel_check_instruction && ch_sel_dec[c] && !msk[c][`CTC_MSK_PAR]) begin
                next_r.trc_branch = r.lat_par[c];
                next_r.lat_par[c] = 1'b0;
            end
        end
        if (cpu.reset_data_channel_instruction && cpu.ch_sel == 3'h0) begin
            next_r.lat_urec = 1'b0;
            next_r.lat_tele = 1'b0;
            next_r.lat_host = 1'b0;
        end

        // requests per channel, mask gated
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            req[c] = (r.lat_opc[c] && msk[c][`CTC_MSK_OPC])
                   || (r.lat_par[c] && msk[c][`CTC_MSK_PAR]
                       && !sync2.in_use[c])
                   || (r.lat_xatt[c] && msk[c][`CTC_MSK_ATT]);
        end
        req[0] = req[0]
               || (r.lat_urec && msk[0][`CTC_MSK_OPC] && !sync2.in_use[0])
               || (r.lat_tele && msk[0][`CTC_MSK_ATT])
               || (r.lat_host && msk[0][`CTC_MSK_ATT]);

        // priority E, D, C, B, then A
        win = 3'h0;
        any = 1'b0;
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            if (req[c]) begin
                win = 3'(c);
                any = 1'b1;
            end
        end

        // record word for the winner
        rec = '0;
        rec[`CTC_ADDR_W-1:0] = cpu.instr_ctr;
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            if (3'(c) == win) begin
                rec[wb(`CTC_BIT_OPC)] = r.lat_opc[c] && msk[c][`CTC_MSK_OPC];
                rec[wb(`CTC_BIT_PAR)] = r.lat_par[c] && msk[c][`CTC_MSK_PAR];
                rec[wb(`CTC_BIT_XATT)] = r.lat_xatt[c] && msk[c][`CTC_MSK_ATT];
            end
        end
        if (win == 3'h0) begin
            rec[wb(`CTC_BIT_UREC)] = r.lat_urec && msk[0][`CTC_MSK_OPC];
            rec[wb(`CTC_BIT_TELE)] = r.lat_tele && msk[0][`CTC_MSK_ATT];
            rec[wb(`CTC_BIT_HOST)] = r.lat_host && msk[0][`CTC_MSK_ATT];
        end

        // privileged instruction shields the next instruction
        if (cpu.end_op) begin
            next_r.priv_hold = cpu.priv_instr;
        end

        case (r.state)
            CTC_IDLE: begin
                if (cpu.end_op && !r.priv_hold && !cpu.priv_instr
                    && cpu.trap_ctl && r.ch_trap_ctl
                    && !cpu.higher_trap && any) begin
                    next_r.state          = CTC_STORE;
                    next_r.ch_trap_ctl    = 1'b0;
                    next_r.trap.store     = 1'b1;
                    next_r.trap.store_addr = rec_addr(win);
                    next_r.trap.store_data = rec;
                    // recognised and unmasked latches drop
                    for (int c = 0; c < `CTC_NUM_CH; c++) begin
                        if (3'(c) == win) begin
                            if (msk[c][`CTC_MSK_OPC]) next_r.lat_opc[c] = 1'b0;
                            if (msk[c][`CTC_MSK_PAR]) next_r.lat_par[c] = 1'b0;
                            if (msk[c][`CTC_MSK_ATT]) next_r.lat_xatt[c] = 1'b0;
                        end
                    end
                    if (win == 3'h0) begin
                        if (msk[0][`CTC_MSK_OPC]) next_r.lat_urec = 1'b0;
                        if (msk[0][`CTC_MSK_ATT]) next_r.lat_tele = 1'b0;
                        if (msk[0][`CTC_MSK_ATT]) next_r.lat_host = 1'b0;
                    end
                end
            end
            CTC_STORE: begin
                next_r.state            = CTC_IDLE;
                next_r.trap.vector      = 1'b1;
                next_r.trap.vector_addr = r.trap.store_addr + 15'h0001;
            end
            default: next_r.state = CTC_IDLE;
        endcase

        // enable-traps loads selected mask and restores trigger
        if (cpu.enable_traps_instruction) begin
            next_r.mask[cpu.ch_sel*4 +: 4] = enb_mask;
            next_r.ch_trap_ctl = 1'b1;
        end
        if (cpu.restore_channel_trap_instruction) begin
            next_r.ch_trap_ctl = 1'b1;
        end
        if (clr2) begin
            next_r.mask     = '0;
            next_r.lat_opc  = '0;
            next_r.lat_par  = '0;
            next_r.lat_xatt = '0;
            next_r.lat_urec = 1'b0;
            next_r.lat_tele = 1'b0;
            next_r.lat_host = 1'b0;
        end

        // sets last: an event in the clearing cycle must not be lost
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            if (r.busy_q[c] && !sync2.in_use[c]) begin
                next_r.lat_opc[c] = 1'b1;
            end
            if (sync2.parity_err[c]) begin
                next_r.lat_par[c] = 1'b1;
            end
            if (sync2.ext_attn[c] && c != 0) begin
                next_r.lat_xatt[c] = 1'b1;
            end
        end
        if (sync2.unit_rec)  next_r.lat_urec = 1'b1;
        if (sync2.tele)      next_r.lat_tele = 1'b1;
        if (sync2.host_attn) next_r.lat_host = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        for (int c = 0; c < `CTC_NUM_CH; c++) begin
            xfer_stop[c] = r.lat_par[c] && r.mask[c*4 + `CTC_MSK_PAR];
        end
        // channel freezes its address register on the stopped word
        addr_hold   = xfer_stop;
        trap        = r.trap;
        trc_branch  = r.trc_branch;
        ch_trap_ctl = r.ch_trap_ctl;
    end

endmodule

/* File: verif/ctc_trap_ctrl_props.sv */
// assertions on the ports of the channel trap control block
// assumes ctc_pkg is compiled first; attached by bind below
`timescale 1ns/10ps
module ctc_trap_ctrl_props
    import ctc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire ctc_chan_s   chan,
    input  wire ctc_cpu_s    cpu,
    input  wire ctc_trap_s   trap,
    input  wire logic [4:0]  xfer_stop,
    input  wire logic [4:0]  addr_hold,
    input  wire logic        trc_branch,
    input  wire logic        ch_trap_ctl
);
    // ======================================
    // record, vector, trap gates and control outputs
    // address field plus the six cause positions
    localparam ctc_word_t REC_OK = 36'h00f0c7fff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_vector_next;
        ##1 (trap.vector && trap.vector_addr == $past(trap.store_addr) + 15'h1);
    endsequence
    sequence s_vector_drop;
        ##1 !trap.vector;
    endsequence
    a_vector_after_store: assert property (trap.store |-> s_vector_next)
        else $error("vector missing after store");
    a_vector_one_cycle: assert property (trap.store |-> s_vector_next ##0 s_vector_drop)
        else $error("vector longer than one cycle");
    a_record_addr_legal: assert property (trap.store |-> trap.store_addr inside
        {15'h000a, 15'h000c, 15'h000e, 15'h0010, 15'h0012})
        else $error("record address not a channel record");
    a_record_fields_clean: assert property (trap.store |-> ((trap.store_data & ~REC_OK) == '0
        && trap.store_data[14:0] == $past(cpu.instr_ctr)))
        else $error("record word fields wrong");
    a_take_needs_gates: assert property (trap.store |-> $past(cpu.end_op && cpu.trap_ctl
        && ch_trap_ctl && !cpu.higher_trap && !cpu.priv_instr))
        else $error("trap taken without its gates");
    a_no_priv_take: assert property (cpu.end_op && cpu.priv_instr |=> !trap.store)
        else $error("trap right after privileged instruction");
    a_take_clears_ctl: assert property (trap.store |-> !ch_trap_ctl)
        else $error("channel trap control left on");
    a_ctl_rise_cmd: assert property ($rose(ch_trap_ctl) |-> $past(cpu.enable_traps_instruction || cpu.restore_channel_trap_instruction))
        else $error("channel trap control set without command");
    a_trc_after_cmd: assert property (trc_branch |-> $past(cpu.branch_on_channel_check_instruction))
        else $error("branch without check instruction");
    a_stop_hold_same: assert property (addr_hold == xfer_stop)
        else $error("address hold differs from transfer stop");
endmodule
bind ctc_trap_ctrl ctc_trap_ctrl_props i_ctc_trap_ctrl_props (.ref_clk, .nrst, .chan, .cpu,
    .trap, .xfer_stop, .addr_hold, .trc_branch, .ch_trap_ctl);

/* File: verif/ctc_chan_model.sv */
// behavioural model of the data channels feeding the trap block
// assumes the bench calls its tasks; all changes land on rising edges
`timescale 1ns/10ps
module ctc_chan_model
    import ctc_pkg::*;
(
    input  wire logic  ref_clk,
    output ctc_chan_s  chan
);
    // ======================================
    // channel activity
    initial chan = '0;
    task busy(input logic [4:0] m);
        @(posedge ref_clk);
        chan.in_use <= m;
    endtask
    task finish(input logic [4:0] m);
        busy(m);
        repeat (4) @(posedge ref_clk);
        busy(5'h00);
    endtask
    // held four cycles so the two-flop synchroniser cannot miss it
    task pulse(input logic attn, input int ch);
        @(posedge ref_clk);
        if (attn) chan.ext_attn[ch] <= 1'b1;
        else chan.parity_err[ch] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chan.ext_attn <= '0;
        chan.parity_err <= '0;
    endtask
    // channel A sources, k = {unit record, teleprocessing, host attention}
    task pulse_a(input logic [2:0] k);
        @(posedge ref_clk);
        {chan.unit_rec, chan.tele, chan.host_attn} <= k;
        repeat (4) @(posedge ref_clk);
        {chan.unit_rec, chan.tele, chan.host_attn} <= 3'h0;
    endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the channel trap control block
// assumes design, checker and channel model are compiled before it
`timescale 1ns/10ps
module tb
    import ctc_pkg::*;
;
    // ======================================
    // harness
    logic        ref_clk;
    logic        nrst;
    ctc_chan_s   chan;
    ctc_cpu_s    cpu;
    ctc_trap_s   trap;
    logic [4:0]  xfer_stop;
    logic [4:0]  addr_hold;
    logic        trc_branch;
    logic        ch_trap_ctl;
    int          err_count;
    int          checked;
    int          cycles;
    ctc_addr_t   rec [5] = '{15'h000a, 15'h000c, 15'h000e, 15'h0010, 15'h0012};
    ctc_trap_ctrl i_ctc_trap_ctrl (.ref_clk, .nrst, .chan, .cpu, .trap, .xfer_stop,
        .addr_hold, .trc_branch, .ch_trap_ctl);
    ctc_chan_model i_ctc_chan_model (.ref_clk, .chan);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task chk(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            summarize();
        end
    end
    // async inputs need the synchroniser plus the latch
    task wt;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    // k = {enable, restore, reset channel, branch on check}
    task cmd(input logic [3:0] k, input logic [2:0] ch, input ctc_word_t w);
        @(posedge ref_clk);
        {cpu.enable_traps_instruction, cpu.restore_channel_trap_instruction, cpu.reset_data_channel_instruction, cpu.branch_on_channel_check_instruction} <= k;
        cpu.ch_sel <= ch;
        cpu.enb_word <= w;
        @(posedge ref_clk);
        {cpu.enable_traps_instruction, cpu.restore_channel_trap_instruction, cpu.reset_data_channel_instruction, cpu.branch_on_channel_check_instruction} <= 4'h0;
        #1;
    endtask
    task take(input logic exp, input ctc_addr_t a, input ctc_word_t d);
        @(posedge ref_clk);
        cpu.end_op <= 1'b1;
        @(posedge ref_clk);
        cpu.end_op <= 1'b0;
        #1;
        chk(trap.store, exp);
        if (exp) begin
            chk(trap.store_addr, a);
            chk(trap.store_data, d);
            chk(ch_trap_ctl, 1'b0);
            @(posedge ref_clk);
            #1;
            chk(trap.vector, 1'b1);
            chk(trap.vector_addr, a + 15'h1);
        end
    endtask
    // ======================================
    // scenarios
    initial begin
        nrst = 1'b0;
        cpu = '0;
        err_count = 0;
        checked = 0;
        cycles = 0;
        cpu.trap_ctl = 1'b1;
        cpu.instr_ctr = 15'h0045;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        chk(ch_trap_ctl, 1'b0);
        chk(xfer_stop, 5'h00);
        for (int i = 0; i < 5; i++) cmd(4'h8, 3'(i), 36'h2);
        chk(ch_trap_ctl, 1'b1);
        i_ctc_chan_model.finish(5'h1f);
        wt();
        for (int i = 4; i >= 0; i--) begin
            take(1'b1, rec[i], 36'h000040045);
            cmd(4'h4, 3'h0, 36'h0);
        end
        // trap control, higher trap and privileged gates closed in turn, then the held-off trap
        i_ctc_chan_model.finish(5'h02);
        wt();
        cpu.trap_ctl <= 1'b0;
        take(1'b0, rec[1], 36'h0);
        cpu.trap_ctl <= 1'b1;
        cpu.higher_trap <= 1'b1;
        take(1'b0, rec[1], 36'h0);
        cpu.higher_trap <= 1'b0;
        cpu.priv_instr <= 1'b1;
        take(1'b0, rec[1], 36'h0);
        cpu.priv_instr <= 1'b0;
        take(1'b0, rec[1], 36'h0);
        take(1'b1, rec[1], 36'h000040045);
        take(1'b0, rec[1], 36'h0);
        cmd(4'h8, 3'h1, 36'h80000);
        i_ctc_chan_model.busy(5'h02);
        i_ctc_chan_model.pulse(1'b0, 1);
        wt();
        chk(xfer_stop, 5'h02);
        chk(addr_hold, 5'h02);
        cmd(4'h1, 3'h1, 36'h0);
        chk(trc_branch, 1'b0);
        take(1'b0, rec[1], 36'h0);
        cmd(4'h8, 3'h1, 36'h0);
        chk(xfer_stop, 5'h00);
        cmd(4'h8, 3'h1, 36'h80000);
        chk(xfer_stop, 5'h02);
        i_ctc_chan_model.busy(5'h00);
        wt();
        take(1'b1, rec[1], 36'h000080045);
        chk(xfer_stop, 5'h00);
        cmd(4'h8, 3'h1, 36'h2);
        take(1'b1, rec[1], 36'h000040045);
        i_ctc_chan_model.pulse(1'b0, 1);
        wt();
        cmd(4'h1, 3'h1, 36'h0);
        chk(trc_branch, 1'b1);
        cmd(4'h1, 3'h1, 36'h0);
        chk(trc_branch, 1'b0);
        cmd(4'h8, 3'h2, 36'h10000000);
        i_ctc_chan_model.busy(5'h04);
        i_ctc_chan_model.pulse(1'b1, 2);
        wt();
        take(1'b1, rec[2], 36'h001000045);
        i_ctc_chan_model.busy(5'h00);
        wt();
        cmd(4'h2, 3'h2, 36'h0);
        cmd(4'h8, 3'h2, 36'h2);
        take(1'b0, rec[2], 36'h0);
        // host attention on channel A, attention mask only
        cmd(4'h8, 3'h0, 36'h10000000);
        i_ctc_chan_model.pulse_a(3'h1);
        wt();
        take(1'b1, rec[0], 36'h002000045);
        // console clear drops mask and latches
        cmd(4'h8, 3'h1, 36'h80000);
        i_ctc_chan_model.pulse(1'b0, 1);
        wt();
        chk(xfer_stop, 5'h02);
        cpu.console_clr <= 1'b1;
        wt();
        cpu.console_clr <= 1'b0;
        wt();
        chk(xfer_stop, 5'h00);
        summarize();
    end
endmodule
